// ### verilog/dac_cfg_pkg.sv
// Package with register map, field positions, reset values and widths of the DAC path slice
package dac_cfg_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int REG_ADDR_W   = 8;
	localparam int REG_DATA_W   = 8;
	localparam int SAMPLE_W_DEF = 16;
	localparam int OFFSET_W     = 13;
	localparam int OFFSET_LO_W  = 8;
	localparam int OFFSET_HI_W  = 5;
	localparam int LANES        = 2;
	localparam int LANE_A       = 0;
	localparam int LANE_B       = 1;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [REG_ADDR_W-1:0] ADDR_POLARITY_ALIGN = 8'h12;
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_SELECT   = 8'h13;
	localparam logic [REG_ADDR_W-1:0] ADDR_OFFSET_A_LO    = 8'h14;
	localparam logic [REG_ADDR_W-1:0] ADDR_OFFSET_B_LO    = 8'h15;
	localparam logic [REG_ADDR_W-1:0] ADDR_OFFSET_A_HI    = 8'h16;
	localparam logic [REG_ADDR_W-1:0] ADDR_OFFSET_B_HI    = 8'h17;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_INVERT_A    = 3;
	localparam int BIT_INVERT_B    = 2;
	localparam int BIT_ALIGN_ENA   = 1;
	localparam int BIT_COPY_A_TO_B = 7;
	localparam int BIT_COPY_B_TO_A = 6;
	localparam int BIT_ALIGN_SEL   = 1;
	localparam int BIT_REVERSE     = 0;
	localparam int OFFSET_HI_LSB   = 3;

	// ------------------------------------------------------------
	// Writable masks and reset values
	// ------------------------------------------------------------
	localparam logic [REG_DATA_W-1:0] MASK_POLARITY_ALIGN = 8'h0E;
	localparam logic [REG_DATA_W-1:0] MASK_ROUTE_SELECT   = 8'hC3;
	localparam logic [REG_DATA_W-1:0] MASK_OFFSET_HI      = 8'hF8;
	localparam logic [REG_DATA_W-1:0] RST_POLARITY_ALIGN  = 8'h02;
	localparam logic [REG_DATA_W-1:0] RST_ROUTE_SELECT    = 8'h00;
	localparam logic [REG_DATA_W-1:0] RST_OFFSET_LO       = 8'h00;
	localparam logic [REG_DATA_W-1:0] RST_OFFSET_HI       = 8'h00;
	localparam logic [REG_DATA_W-1:0] READ_UNMAPPED       = 8'h00;

	// ------------------------------------------------------------
	// Alignment source codes
	// ------------------------------------------------------------
	localparam logic ALIGN_SRC_STROBE = 1'b0;
	localparam logic ALIGN_SRC_FRAME  = 1'b1;

endpackage

// ### verilog/sample_lane.sv
// One converter lane: offset add with saturation, then optional complement
module sample_lane
	import dac_cfg_pkg::*;
#(
	parameter int SAMPLE_W = SAMPLE_W_DEF
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Sample in
	input  wire logic                valid_i,
	input  wire logic [SAMPLE_W-1:0] sample_i,
	input  wire logic [OFFSET_W-1:0] offset_i,
	input  wire logic                invert_i,
	// Sample out
	output logic                     valid_o,
	output logic [SAMPLE_W-1:0]      data_o
);

	localparam logic [SAMPLE_W-1:0] POS_FULL = {1'b0, {(SAMPLE_W-1){1'b1}}};
	localparam logic [SAMPLE_W-1:0] NEG_FULL = {1'b1, {(SAMPLE_W-1){1'b0}}};

	logic [SAMPLE_W:0]   sum;
	logic [SAMPLE_W-1:0] clipped;
	logic [SAMPLE_W-1:0] next_data;
	logic                next_valid;

	always_comb begin
		// One guard bit is enough: offset is narrower than the sample
		sum = {sample_i[SAMPLE_W-1], sample_i}
			+ {{(SAMPLE_W+1-OFFSET_W){offset_i[OFFSET_W-1]}}, offset_i}; // see [RULE15]
		if (sum[SAMPLE_W] != sum[SAMPLE_W-1]) begin
			clipped = sum[SAMPLE_W] ? NEG_FULL : POS_FULL; // see [RULE15]
		end else begin
			clipped = sum[SAMPLE_W-1:0];
		end
		// Complement comes last so it acts like swapped data lines at the converter
		next_data  = invert_i ? ~clipped : clipped; // see [RULE1] see [RULE2]
		next_valid = valid_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o  <= '0;
			valid_o <= 1'b0;
		end else begin
			data_o  <= next_data;
			valid_o <= next_valid;
		end
	end

endmodule

// ### verilog/align_select.sv
// Alignment source choice and one-cycle divider realign pulse
module align_select
	import dac_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic enable_i,
	input  wire logic source_sel_i,
	// Sources
	input  wire logic ext_align_strobe_i,
	input  wire logic frame_marker_i,
	// Pulse out
	output logic      realign_o
);

	logic chosen;
	logic chosen_q;
	logic next_chosen_q;
	logic next_realign;

	always_comb begin
		chosen        = (source_sel_i == ALIGN_SRC_FRAME) ? frame_marker_i : ext_align_strobe_i; // see [RULE7]
		next_chosen_q = chosen;
		// Rising edge only, so a long strobe realigns once
		next_realign  = enable_i && chosen && !chosen_q; // see [RULE3]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chosen_q  <= 1'b0;
			realign_o <= 1'b0;
		end else begin
			chosen_q  <= next_chosen_q;
			realign_o <= next_realign;
		end
	end

endmodule

// ### verilog/dac_path_cfg.sv
// Top of the DAC data path configuration slice: registers, autosync, routing and lanes
//
// Contract
// [RULE1] Invert bit complements converter A data
// [RULE2] Invert bit complements converter B data
// [RULE3] Align enable gates divider realign from source
// [RULE4] Host aligns divider only during initialisation
// [RULE5] Copy bit drives channel A onto B
// [RULE6] Copy bit drives channel B onto A
// [RULE7] Select bit picks strobe or frame marker
// [RULE8] Reverse bit mirrors input word bit order
// [RULE9] Register 0x14 holds A offset low byte
// [RULE10] Register 0x15 holds B offset low byte
// [RULE11] Writing 0x14 loads all offsets together
// [RULE12] Other offset writes only touch shadow copies
// [RULE13] Host writes channel A low byte last
// [RULE14] Upper five offset bits at 0x16, 0x17
// [RULE15] Add signed offset, saturate at full scale
module dac_path_cfg
	import dac_cfg_pkg::*;
#(
	parameter int SAMPLE_W = SAMPLE_W_DEF
) (
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  SYS_RST_I,
	// Register port
	input  wire logic                  REG_WR_I,
	input  wire logic                  REG_RD_I,
	input  wire logic [REG_ADDR_W-1:0] REG_ADDR_I,
	input  wire logic [REG_DATA_W-1:0] REG_WDATA_I,
	output logic      [REG_DATA_W-1:0] REG_RDATA_O,
	output logic                       REG_RVALID_O,
	// Input samples
	input  wire logic                  SAMPLE_VALID_I,
	input  wire logic [SAMPLE_W-1:0]   SAMPLE_A_I,
	input  wire logic [SAMPLE_W-1:0]   SAMPLE_B_I,
	// Alignment sources
	input  wire logic                  EXT_ALIGN_STROBE_I,
	input  wire logic                  FRAME_MARKER_I,
	// Converter data
	output logic                       DAC_VALID_O,
	output logic      [SAMPLE_W-1:0]   DAC_A_O,
	output logic      [SAMPLE_W-1:0]   DAC_B_O,
	// Status
	output logic                       DIV_ALIGN_O,
	output logic      [OFFSET_W-1:0]   ACTIVE_OFFSET_A_O,
	output logic      [OFFSET_W-1:0]   ACTIVE_OFFSET_B_O
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [SAMPLE_W-1:0] mirror(input logic [SAMPLE_W-1:0] word);
		logic [SAMPLE_W-1:0] res;
		res = '0;
		for (int k = 0; k < SAMPLE_W; k++) begin
			res[k] = word[SAMPLE_W-1-k];
		end
		return res;
	endfunction

	function automatic logic hit(input logic [REG_ADDR_W-1:0] addr,
	                             input logic [REG_ADDR_W-1:0] target,
	                             input logic                  strobe);
		return strobe && (addr == target);
	endfunction

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [REG_DATA_W-1:0] polarity_align;
	logic [REG_DATA_W-1:0] route_select;
	logic [REG_DATA_W-1:0] offset_a_lo;
	logic [REG_DATA_W-1:0] offset_b_lo;
	logic [REG_DATA_W-1:0] offset_a_hi;
	logic [REG_DATA_W-1:0] offset_b_hi;
	logic [OFFSET_W-1:0]   active_a;
	logic [OFFSET_W-1:0]   active_b;

	logic [REG_DATA_W-1:0] next_polarity_align;
	logic [REG_DATA_W-1:0] next_route_select;
	logic [REG_DATA_W-1:0] next_offset_a_lo;
	logic [REG_DATA_W-1:0] next_offset_b_lo;
	logic [REG_DATA_W-1:0] next_offset_a_hi;
	logic [REG_DATA_W-1:0] next_offset_b_hi;
	logic [OFFSET_W-1:0]   next_active_a;
	logic [OFFSET_W-1:0]   next_active_b;
	logic [REG_DATA_W-1:0] next_rdata;
	logic                  next_rvalid;
	logic                  wr_polarity;
	logic                  wr_route;
	logic                  wr_b_lo;
	logic                  wr_a_hi;
	logic                  wr_b_hi;
	logic                  autosync;

	// One decoder per strike; the write process only reads the results
	assign wr_polarity = hit(REG_ADDR_I, ADDR_POLARITY_ALIGN, REG_WR_I);
	assign wr_route    = hit(REG_ADDR_I, ADDR_ROUTE_SELECT, REG_WR_I);
	assign wr_b_lo     = hit(REG_ADDR_I, ADDR_OFFSET_B_LO, REG_WR_I);
	assign wr_a_hi     = hit(REG_ADDR_I, ADDR_OFFSET_A_HI, REG_WR_I);
	assign wr_b_hi     = hit(REG_ADDR_I, ADDR_OFFSET_B_HI, REG_WR_I);
	// Any write to the A low byte triggers the autosync, whatever the data
	assign autosync    = hit(REG_ADDR_I, ADDR_OFFSET_A_LO, REG_WR_I); // see [RULE11]

	always_comb begin
		next_polarity_align = polarity_align;
		next_route_select   = route_select;
		next_offset_a_lo    = offset_a_lo;
		next_offset_b_lo    = offset_b_lo;
		next_offset_a_hi    = offset_a_hi;
		next_offset_b_hi    = offset_b_hi;
		next_active_a       = active_a;
		next_active_b       = active_b;
		// Reserved bits are dropped here, so read-back shows them as zero
		if (wr_polarity) begin
			next_polarity_align = REG_WDATA_I & MASK_POLARITY_ALIGN;
		end
		if (wr_route) begin
			next_route_select = REG_WDATA_I & MASK_ROUTE_SELECT;
		end
		// Shadow-only writes; active offsets stay put
		if (wr_b_lo) begin
			next_offset_b_lo = REG_WDATA_I; // see [RULE10] see [RULE12]
		end
		if (wr_a_hi) begin
			next_offset_a_hi = REG_WDATA_I & MASK_OFFSET_HI; // see [RULE14] see [RULE12]
		end
		if (wr_b_hi) begin
			next_offset_b_hi = REG_WDATA_I & MASK_OFFSET_HI; // see [RULE14] see [RULE12]
		end
		// Autosync: the new A low byte is taken from the bus so it lands in the same edge
		if (autosync) begin
			next_offset_a_lo = REG_WDATA_I; // see [RULE9]
			next_active_a    = {offset_a_hi[REG_DATA_W-1:OFFSET_HI_LSB], REG_WDATA_I}; // see [RULE11]
			next_active_b    = {offset_b_hi[REG_DATA_W-1:OFFSET_HI_LSB], offset_b_lo}; // see [RULE11]
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			polarity_align <= RST_POLARITY_ALIGN;
			route_select   <= RST_ROUTE_SELECT;
			offset_a_lo    <= RST_OFFSET_LO;
			offset_b_lo    <= RST_OFFSET_LO;
			offset_a_hi    <= RST_OFFSET_HI;
			offset_b_hi    <= RST_OFFSET_HI;
			active_a       <= '0;
			active_b       <= '0;
		end else begin
			polarity_align <= next_polarity_align;
			route_select   <= next_route_select;
			offset_a_lo    <= next_offset_a_lo;
			offset_b_lo    <= next_offset_b_lo;
			offset_a_hi    <= next_offset_a_hi;
			offset_b_hi    <= next_offset_b_hi;
			active_a       <= next_active_a;
			active_b       <= next_active_b;
		end
	end

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	// Named once so the datapath below never indexes raw register bits
	logic invert_a;
	logic invert_b;
	logic align_ena;
	logic copy_a_to_b;
	logic copy_b_to_a;
	logic align_sel;
	logic reverse_bits;

	assign invert_a     = polarity_align[BIT_INVERT_A]; // see [RULE1]
	assign invert_b     = polarity_align[BIT_INVERT_B]; // see [RULE2]
	assign align_ena    = polarity_align[BIT_ALIGN_ENA]; // see [RULE3]
	assign copy_a_to_b  = route_select[BIT_COPY_A_TO_B]; // see [RULE5]
	assign copy_b_to_a  = route_select[BIT_COPY_B_TO_A]; // see [RULE6]
	assign align_sel    = route_select[BIT_ALIGN_SEL]; // see [RULE7]
	assign reverse_bits = route_select[BIT_REVERSE]; // see [RULE8]

	// ------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------
	// A read in the same cycle as a write returns the value before the write
	always_comb begin
		next_rvalid = REG_RD_I;
		// Data holds between reads; only the valid pulse marks a fresh answer
		next_rdata  = REG_RDATA_O;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				ADDR_POLARITY_ALIGN: begin
					next_rdata = polarity_align;
				end
				ADDR_ROUTE_SELECT: begin
					next_rdata = route_select;
				end
				ADDR_OFFSET_A_LO: begin
					next_rdata = offset_a_lo;
				end
				ADDR_OFFSET_B_LO: begin
					next_rdata = offset_b_lo;
				end
				ADDR_OFFSET_A_HI: begin
					next_rdata = offset_a_hi;
				end
				ADDR_OFFSET_B_HI: begin
					next_rdata = offset_b_hi;
				end
				default: begin
					next_rdata = READ_UNMAPPED;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			REG_RDATA_O       <= READ_UNMAPPED;
			REG_RVALID_O      <= 1'b0;
			ACTIVE_OFFSET_A_O <= '0;
			ACTIVE_OFFSET_B_O <= '0;
		end else begin
			REG_RDATA_O       <= next_rdata;
			REG_RVALID_O      <= next_rvalid;
			ACTIVE_OFFSET_A_O <= next_active_a;
			ACTIVE_OFFSET_B_O <= next_active_b;
		end
	end

	// ------------------------------------------------------------
	// Input ordering and channel routing
	// ------------------------------------------------------------
	logic [SAMPLE_W-1:0] word_a;
	logic [SAMPLE_W-1:0] word_b;
	logic [SAMPLE_W-1:0] routed [LANES];
	logic                routed_valid;
	logic [SAMPLE_W-1:0] next_routed [LANES];
	logic                next_routed_valid;

	always_comb begin
		word_a = reverse_bits ? mirror(SAMPLE_A_I) : SAMPLE_A_I; // see [RULE8]
		word_b = reverse_bits ? mirror(SAMPLE_B_I) : SAMPLE_B_I; // see [RULE8]
		// Both copy bits set swaps the channels
		next_routed[LANE_A] = copy_b_to_a ? word_b : word_a; // see [RULE6]
		next_routed[LANE_B] = copy_a_to_b ? word_a : word_b; // see [RULE5]
		next_routed_valid   = SAMPLE_VALID_I;
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			routed[LANE_A] <= '0;
			routed[LANE_B] <= '0;
			routed_valid   <= 1'b0;
		end else begin
			routed[LANE_A] <= next_routed[LANE_A];
			routed[LANE_B] <= next_routed[LANE_B];
			routed_valid   <= next_routed_valid;
		end
	end

	// ------------------------------------------------------------
	// Converter lanes
	// ------------------------------------------------------------
	logic [OFFSET_W-1:0] lane_offset [LANES];
	logic                lane_invert [LANES];
	logic [SAMPLE_W-1:0] lane_data   [LANES];
	logic                lane_valid  [LANES];

	assign lane_offset[LANE_A] = active_a;
	assign lane_offset[LANE_B] = active_b;
	assign lane_invert[LANE_A] = invert_a;
	assign lane_invert[LANE_B] = invert_b;

	generate
		for (genvar g = 0; g < LANES; g++) begin : g_lane
			sample_lane #(
				.SAMPLE_W (SAMPLE_W)
			) u_lane (
				.clk_i    (CLK_I),
				.rst_i    (SYS_RST_I),
				.valid_i  (routed_valid),
				.sample_i (routed[g]),
				.offset_i (lane_offset[g]),
				.invert_i (lane_invert[g]),
				.valid_o  (lane_valid[g]),
				.data_o   (lane_data[g])
			);
		end
	endgenerate

	assign DAC_A_O     = lane_data[LANE_A];
	assign DAC_B_O     = lane_data[LANE_B];
	assign DAC_VALID_O = lane_valid[LANE_A];

	// ------------------------------------------------------------
	// Divider alignment
	// ------------------------------------------------------------
	// Realigning mid-stream shifts the divider phase; software keeps it to bring-up
	align_select u_align (
		.clk_i              (CLK_I),
		.rst_i              (SYS_RST_I),
		.enable_i           (align_ena),
		.source_sel_i       (align_sel),
		.ext_align_strobe_i (EXT_ALIGN_STROBE_I),
		.frame_marker_i     (FRAME_MARKER_I),
		.realign_o          (DIV_ALIGN_O)
	);

endmodule

// ### tb/dac_path_cfg_props.sv
// Port checker for the DAC path configuration slice
module dac_path_cfg_props
	import dac_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic                  CLK_I,
	input  wire logic                  SYS_RST_I,
	// Register port
	input  wire logic                  REG_WR_I,
	input  wire logic                  REG_RD_I,
	input  wire logic [REG_ADDR_W-1:0] REG_ADDR_I,
	input  wire logic [REG_DATA_W-1:0] REG_WDATA_I,
	input  wire logic [REG_DATA_W-1:0] REG_RDATA_O,
	input  wire logic                  REG_RVALID_O,
	// Samples, alignment, offsets
	input  wire logic                  SAMPLE_VALID_I,
	input  wire logic                  EXT_ALIGN_STROBE_I,
	input  wire logic                  FRAME_MARKER_I,
	input  wire logic                  DAC_VALID_O,
	input  wire logic                  DIV_ALIGN_O,
	input  wire logic [OFFSET_W-1:0]   ACTIVE_OFFSET_A_O,
	input  wire logic [OFFSET_W-1:0]   ACTIVE_OFFSET_B_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	logic sync;
	assign sync = REG_WR_I && REG_ADDR_I == ADDR_OFFSET_A_LO;

	property p_rd_ans; REG_RD_I |=> REG_RVALID_O; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_quiet; !REG_RD_I |=> !REG_RVALID_O; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
	property p_rd_hold; !REG_RVALID_O |-> $stable(REG_RDATA_O); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_sync; sync |=> ACTIVE_OFFSET_A_O[7:0] == $past(REG_WDATA_I); endproperty
	a_sync: assert property (p_sync) else $error("offset not loaded");
	property p_shadow; !sync |=> $stable(ACTIVE_OFFSET_A_O) && $stable(ACTIVE_OFFSET_B_O); endproperty
	a_shadow: assert property (p_shadow) else $error("offset moved");
	// Valid must be low during reset so the two-deep history is clean
	property p_lat; DAC_VALID_O == $past(SAMPLE_VALID_I, 2); endproperty
	a_lat: assert property (p_lat) else $error("valid latency");
	property p_pulse; DIV_ALIGN_O |=> !DIV_ALIGN_O; endproperty
	a_pulse: assert property (p_pulse) else $error("align too long");
	property p_cause; DIV_ALIGN_O |-> $past(EXT_ALIGN_STROBE_I || FRAME_MARKER_I); endproperty
	a_cause: assert property (p_cause) else $error("align without source");

	c_sync: cover property (sync ##1 ACTIVE_OFFSET_A_O != 13'h0000);
	c_align: cover property (DIV_ALIGN_O);
	c_read: cover property (REG_RD_I ##1 REG_RVALID_O);
endmodule

bind dac_path_cfg dac_path_cfg_props i_props (.CLK_I, .SYS_RST_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
	.REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .SAMPLE_VALID_I, .EXT_ALIGN_STROBE_I, .FRAME_MARKER_I,
	.DAC_VALID_O, .DIV_ALIGN_O, .ACTIVE_OFFSET_A_O, .ACTIVE_OFFSET_B_O);

// ### tb/dac_host.sv
// Host model that drives the register port
module dac_host (
	// Clock
	input  wire logic       clk_i,
	// Register port
	output logic            wr_o,
	output logic            rd_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// Released lines show the inverse, so stale values are never trusted
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [8:0] q);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		q = {rvalid_i, rdata_i};
	endtask
endmodule

// ### tb/dac_path_cfg_bench.sv
// Self-checking bench for the DAC path configuration slice
module dac_path_cfg_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        s_valid = 1'b0;
	logic        strobe  = 1'b0;
	logic        frame   = 1'b0;
	logic [15:0] s_a     = 16'h1234;
	logic [15:0] s_b     = 16'h00F1;
	logic [12:0] oa      = 13'h0000;
	logic [12:0] ob      = 13'h0000;
	logic        wr, rd, rvalid, d_valid, align;
	logic [7:0]  addr, wdata, rdata, c12, c13;
	logic [15:0] d_a, d_b;
	logic [12:0] act_a, act_b;
	logic [8:0]  q;
	logic [15:0] cfg [8] = '{16'h0200, 16'h0A00, 16'h0600, 16'h0280, 16'h0240, 16'h02C0, 16'h0201, 16'h0EC1};
	int          failures  = 0;
	int          tests_run = 0;
	int          cycles    = 0;

	always #10 clk = ~clk;

	dac_path_cfg i_dac_path_cfg (.CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.SAMPLE_VALID_I(s_valid), .SAMPLE_A_I(s_a), .SAMPLE_B_I(s_b), .EXT_ALIGN_STROBE_I(strobe),
		.FRAME_MARKER_I(frame), .DAC_VALID_O(d_valid), .DAC_A_O(d_a), .DAC_B_O(d_b),
		.DIV_ALIGN_O(align), .ACTIVE_OFFSET_A_O(act_a), .ACTIVE_OFFSET_B_O(act_b));
	dac_host host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
		.rdata_i(rdata), .rvalid_i(rvalid));

	// --------
	// Helpers
	// --------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end

	task rdchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, q);
		check(16'(q), {7'h00, 1'b1, e});
	endtask

	// Signed add with clamp to full scale, then optional complement
	function automatic logic [15:0] lane(input logic [15:0] s, input logic [12:0] o, input logic inv);
		logic [16:0] t;
		t = {s[15], s} + {{4{o[12]}}, o};
		if (t[16] != t[15]) t[15:0] = t[16] ? 16'h8000 : 16'h7FFF;
		return inv ? ~t[15:0] : t[15:0];
	endfunction

	task lanes;
		logic [15:0] ra, rb, a, b;
		for (int i = 0; i < 16; i++) begin
			ra[i] = c13[0] ? s_a[15-i] : s_a[i];
			rb[i] = c13[0] ? s_b[15-i] : s_b[i];
		end
		a = c13[6] ? rb : ra;
		b = c13[7] ? ra : rb;
		repeat (3) @(posedge clk);
		#1;
		check(d_a, lane(a, oa, c12[3]));
		check(d_b, lane(b, ob, c12[2]));
	endtask

	task pulse(input logic f, input logic [15:0] n);
		int c;
		c = 0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			frame <= f && i < 3;
			strobe <= !f && i < 3;
			#1;
			c += int'(align);
		end
		check(16'(c), n);
	endtask

	// --------
	// Sequence
	// --------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int a = 18; a < 24; a++) rdchk(8'(a), a == 18 ? 8'h02 : 8'h00);
		host.wr(8'h12, 8'hFF);
		rdchk(8'h12, 8'h0E);
		host.wr(8'h13, 8'hFF);
		rdchk(8'h13, 8'hC3);
		host.wr(8'h18, 8'hA5);
		rdchk(8'h18, 8'h00);
		// Divider alignment only during bring-up, as a host should
		host.wr(8'h13, 8'h00);
		pulse(1'b0, 16'h0001);
		pulse(1'b1, 16'h0000);
		host.wr(8'h13, 8'h02);
		pulse(1'b1, 16'h0001);
		pulse(1'b0, 16'h0000);
		host.wr(8'h12, 8'h00);
		pulse(1'b1, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			s_valid <= i == 0;
			#1;
			check(16'(d_valid), 16'(i == 2));
		end
		foreach (cfg[k]) begin
			c12 = cfg[k][15:8];
			c13 = cfg[k][7:0];
			host.wr(8'h12, c12);
			host.wr(8'h13, c13);
			lanes();
		end
		// Low byte of channel A goes last
		host.wr(8'h16, 8'hFF);
		host.wr(8'h17, 8'h7F);
		rdchk(8'h17, 8'h78);
		host.wr(8'h15, 8'hFF);
		#1;
		check(16'(act_a), 16'h0000);
		check(16'(act_b), 16'h0000);
		host.wr(8'h14, 8'h3C);
		#1;
		check(16'(act_a), 16'h1F3C);
		check(16'(act_b), 16'h0FFF);
		rdchk(8'h15, 8'hFF);
		rdchk(8'h14, 8'h3C);
		oa = 13'h1F3C;
		ob = 13'h0FFF;
		@(posedge clk);
		s_a <= 16'h8005;
		s_b <= 16'h7FF0;
		c13 = 8'h00;
		host.wr(8'h13, c13);
		lanes();
		c13 = 8'hC0;
		host.wr(8'h13, c13);
		lanes();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(8'h12, 8'h02);
		check(16'(act_a), 16'h0000);
		check(16'(act_b), 16'h0000);
		stop_test();
	end
endmodule
